/* File: include/eeprom_ctrl_pkg.sv */
// package: constants, types and the command map of the serial eeprom slave
// assumes: a 10 mhz core clock and a bus clock that runs only within frames
`default_nettype none
package eeprom_ctrl_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 10000;
	localparam int PROG_TIME_MS = 8;
	localparam int PROG_CYCLES = PROG_TIME_MS * CLK_FREQ_KHZ;
	// ------------------------------------------------------------
	// bus command addresses
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_LOAD_LOW = 8'h80;
	localparam logic [7:0] CMD_READ_LOW = 8'h81;
	localparam logic [7:0] CMD_PROG_LOW = 8'h83;
	localparam logic [7:0] CMD_LOAD_HIGH = 8'h84;
	localparam logic [7:0] CMD_READ_HIGH = 8'h85;
	localparam logic [7:0] CMD_PROG_HIGH = 8'h87;
	// ------------------------------------------------------------
	// memory map
	// ------------------------------------------------------------
	localparam int MEM_DEPTH = 512;
	localparam int ADDR_W = 10;
	localparam logic [9:0] MEM_LAST = 10'h1ff;
	localparam logic [9:0] TEST_MODE_BYTE_OFS = 10'h204;
	localparam logic [9:0] PROGRAM_BUSY_STATUS_OFS = 10'h20e;
	localparam logic [7:0] TEST_MODE_BYTE_RST = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int BUSY_BIT = 1;
	// ------------------------------------------------------------
	// test byte fields and address fields
	// ------------------------------------------------------------
	localparam int TB_BLOCK_BIT = 7;
	localparam int TB_ENABLE_BIT = 5;
	localparam int TB_PUMP_OFF_BIT = 3;
	localparam int ADDR_HIGH_BIT = 9;
	localparam logic [1:0] BLOCK_EVEN = 2'h2;
	localparam logic [1:0] BLOCK_ODD = 2'h3;
	localparam logic [1:0] PROT_GROUP = 2'h0;
	localparam int WORD_BITS = 16;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} link_word_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_END = 2'b11
	} frame_state_type;
endpackage
`default_nettype wire

/* File: verilog/link_shifter.sv */
// link-side shift engine, clocked by the bus clock line itself
// assumes frame_select and data meet setup and hold around rising edges
`default_nettype none
module link_shifter (
	input wire logic bus_clock_line_i,
	input wire logic frame_select_i,
	input wire logic data_i,
	input wire logic [15:0] read_word_i,
	input wire logic read_en_i,
	output eeprom_ctrl_pkg::link_word_type word_o,
	output logic data_oe_o
);
	logic [4:0] bit_cnt;
	logic read_bit;
	logic in_window;

	// ------------------------------------------------------------
	// capture on rising edges
	// ------------------------------------------------------------
	// no reset here: the clock only runs inside frames and every
	// address phase restarts the data count anyway
	always_ff @(posedge bus_clock_line_i) begin
		if (!frame_select_i) begin
			word_o.addr <= {data_i, word_o.addr[7:1]};
			bit_cnt <= 5'h00;
		end else begin
			word_o.data <= {data_i, word_o.data[15:1]};
			if (bit_cnt != 5'h10) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// open-drain return path
	// ------------------------------------------------------------
	assign in_window = frame_select_i && (bit_cnt < 5'h10);
	assign read_bit = read_word_i[bit_cnt[3:0]];
	assign data_oe_o = read_en_i && in_window && !read_bit;
endmodule
`default_nettype wire

/* File: verilog/prog_timer.sv */
// self-timed programming interval with abort
// assumes start is a one-cycle pulse from the command logic
`default_nettype none
module prog_timer #(
	parameter int CYCLES = eeprom_ctrl_pkg::PROG_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic abort_i,
	output logic busy_o,
	output logic done_o
);
	logic [23:0] count;
	wire last = (count == 24'h000001);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || abort_i) begin
			count <= 24'h000000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= busy_o && last;
			if (start_i && !busy_o) begin
				count <= 24'(CYCLES);
				busy_o <= 1'b1;
			end else if (busy_o) begin
				count <= count - 24'h000001;
				busy_o <= !last;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/eeprom_slave.sv */
// serial eeprom slave: command decode, array, test byte and busy flag
// assumes a three-wire master and pins that are asynchronous to ref_clk_i
`default_nettype none
module eeprom_slave #(
	parameter int PROG_CYCLES = eeprom_ctrl_pkg::PROG_CYCLES,
	parameter int DEPTH = eeprom_ctrl_pkg::MEM_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic bus_clock_line_i,
	input wire logic frame_select_i,
	input wire logic data_i,
	output logic data_o,
	output logic data_oe_o,
	input wire logic reset_n_i,
	input wire logic option_i,
	input wire logic protect_i,
	output logic busy_o
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	eeprom_ctrl_pkg::link_word_type link_word;
	eeprom_ctrl_pkg::frame_state_type state;
	eeprom_ctrl_pkg::frame_state_type next_state;
	logic [1:0] sel_sync;
	logic [1:0] rstn_sync;
	logic [1:0] opt_sync;
	logic [1:0] prot_sync;
	logic sel_last;
	logic [7:0] cmd;
	logic [15:0] data_word;
	logic apply;
	logic [9:0] mar;
	logic [7:0] test_mode_byte;
	logic [7:0] mem [DEPTH];
	logic [15:0] read_word;
	logic read_en;
	logic prog_start;
	logic busy;
	logic done;
	logic [9:0] prog_addr;
	logic [7:0] prog_data;
	logic prog_block;
	logic prog_pump_off;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			sel_sync <= 2'h3;
			rstn_sync <= 2'h0;
			opt_sync <= 2'h0;
			prot_sync <= 2'h0;
			sel_last <= 1'b1;
		end else begin
			sel_sync <= {sel_sync[0], frame_select_i};
			rstn_sync <= {rstn_sync[0], reset_n_i};
			opt_sync <= {opt_sync[0], option_i};
			prot_sync <= {prot_sync[0], protect_i};
			sel_last <= sel_sync[1];
		end
	end

	wire sel_now = sel_sync[1];
	wire dev_rst = !rstn_sync[1];
	wire opt_high = opt_sync[1];
	wire prot_open = prot_sync[1];
	wire sel_fall = sel_last && !sel_now;
	wire sel_rise = !sel_last && sel_now;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	function automatic logic is_protected(input logic [9:0] a);
		is_protected = (a[5:4] == eeprom_ctrl_pkg::PROT_GROUP);
	endfunction

	function automatic logic block_hit(input logic [9:0] sel,
			input logic [9:0] a);
		if (!sel[1]) begin
			block_hit = 1'b1;
		end else if (sel[1:0] == eeprom_ctrl_pkg::BLOCK_EVEN) begin
			block_hit = !a[0];
		end else if (sel[1:0] == eeprom_ctrl_pkg::BLOCK_ODD) begin
			block_hit = a[0];
		end else begin
			block_hit = 1'b0;
		end
	endfunction

	function automatic logic [7:0] cell_update(input logic [7:0] old,
			input logic [7:0] d);
		// a write of all ones erases; anything else can only clear bits
		if (d == eeprom_ctrl_pkg::ERASED_BYTE) begin
			cell_update = eeprom_ctrl_pkg::ERASED_BYTE;
		end else begin
			cell_update = old & d;
		end
	endfunction

	// only the busy flag is defined in the status byte
	function automatic logic [15:0] status_word(input logic flag);
		status_word = 16'hff00;
		status_word[eeprom_ctrl_pkg::BUSY_BIT] = flag;
	endfunction

	// ------------------------------------------------------------
	// link side
	// ------------------------------------------------------------
	link_shifter u_link (
		.bus_clock_line_i(bus_clock_line_i),
		.frame_select_i(frame_select_i),
		.data_i(data_i),
		.read_word_i(read_word),
		.read_en_i(read_en),
		.word_o(link_word),
		.data_oe_o(data_oe_o)
	);

	// the pin is only ever pulled low; release is by the external pull-up
	assign data_o = 1'b0;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	// link_word.addr is still while select is high, and link_word.data
	// is still once select drops for the end pulse, so both are read
	// only after the synchronised select edge that freezes them
	wire [7:0] base_load = opt_high ? eeprom_ctrl_pkg::CMD_LOAD_HIGH :
		eeprom_ctrl_pkg::CMD_LOAD_LOW;
	wire [7:0] base_read = opt_high ? eeprom_ctrl_pkg::CMD_READ_HIGH :
		eeprom_ctrl_pkg::CMD_READ_LOW;
	wire [7:0] base_prog = opt_high ? eeprom_ctrl_pkg::CMD_PROG_HIGH :
		eeprom_ctrl_pkg::CMD_PROG_LOW;
	wire is_load = (cmd == base_load);
	wire is_read = (cmd == base_read);
	wire is_prog = (cmd == base_prog);
	wire addr_read = (link_word.addr == base_read);

	wire tb_active = test_mode_byte[eeprom_ctrl_pkg::TB_ENABLE_BIT];
	wire tb_block = tb_active &&
		test_mode_byte[eeprom_ctrl_pkg::TB_BLOCK_BIT];
	wire tb_pump_off = tb_active &&
		test_mode_byte[eeprom_ctrl_pkg::TB_PUMP_OFF_BIT];
	wire in_array = (mar <= eeprom_ctrl_pkg::MEM_LAST);
	wire at_test = (mar == eeprom_ctrl_pkg::TEST_MODE_BYTE_OFS);
	wire at_busy = (mar == eeprom_ctrl_pkg::PROGRAM_BUSY_STATUS_OFS);
	wire commit = (state == eeprom_ctrl_pkg::ST_DATA) && sel_fall;

	// ------------------------------------------------------------
	// frame state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			eeprom_ctrl_pkg::ST_IDLE: begin
				if (sel_fall) begin
					next_state = eeprom_ctrl_pkg::ST_ADDR;
				end
			end
			eeprom_ctrl_pkg::ST_ADDR: begin
				if (sel_rise) begin
					next_state = eeprom_ctrl_pkg::ST_DATA;
				end
			end
			eeprom_ctrl_pkg::ST_DATA: begin
				if (sel_fall) begin
					next_state = eeprom_ctrl_pkg::ST_END;
				end
			end
			eeprom_ctrl_pkg::ST_END: begin
				if (sel_rise) begin
					next_state = eeprom_ctrl_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = eeprom_ctrl_pkg::ST_IDLE;
			end
		endcase
	end

	// no timeout anywhere in the frame: a paused master simply holds
	// its lines and the state waits for the next select edge
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || dev_rst) begin
			state <= eeprom_ctrl_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// command capture and read word
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || dev_rst) begin
			cmd <= 8'h00;
			read_en <= 1'b0;
			read_word <= 16'hffff;
		end else if (state == eeprom_ctrl_pkg::ST_ADDR && sel_rise) begin
			cmd <= link_word.addr;
			read_en <= addr_read;
			if (at_busy) begin
				read_word <= status_word(busy);
			end else if (in_array) begin
				// data during busy is whatever the array holds
				read_word <= {8'hff, mem[mar[8:0]]};
			end else begin
				read_word <= 16'hffff;
			end
		end else if (state == eeprom_ctrl_pkg::ST_DATA && sel_fall) begin
			read_en <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			data_word <= 16'h0000;
			apply <= 1'b0;
		end else begin
			// every consumer acts a cycle later on this core-side copy
			apply <= commit && !dev_rst;
			if (commit) begin
				data_word <= link_word.data;
			end
		end
	end

	// ------------------------------------------------------------
	// address register and test byte
	// ------------------------------------------------------------
	wire [9:0] word_addr = data_word[9:0];
	// the busy flag must stay reachable while busy, so a load of its own
	// location still gets through then; every other load is dropped
	wire load_ok = !busy ||
		(word_addr == eeprom_ctrl_pkg::PROGRAM_BUSY_STATUS_OFS);

	// srst_i sets a known value at power-up; the reset pin keeps it
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mar <= 10'h000;
		end else if (apply && is_load && load_ok && !dev_rst) begin
			mar <= word_addr;
		end
	end

	// refused while busy, so a running cycle keeps the mode it began with
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || dev_rst) begin
			test_mode_byte <= eeprom_ctrl_pkg::TEST_MODE_BYTE_RST;
		end else if (apply && is_prog && !busy && at_test) begin
			test_mode_byte <= data_word[7:0];
		end
	end

	// ------------------------------------------------------------
	// programming
	// ------------------------------------------------------------
	// a program to 516 only touches the test byte, so nothing is timed
	assign prog_start = apply && is_prog && !busy && !dev_rst &&
		in_array;
	wire block_ok = tb_block &&
		!mar[eeprom_ctrl_pkg::ADDR_HIGH_BIT];

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			prog_addr <= 10'h000;
			prog_data <= eeprom_ctrl_pkg::ERASED_BYTE;
			prog_block <= 1'b0;
			prog_pump_off <= 1'b0;
		end else if (prog_start) begin
			prog_addr <= mar;
			prog_data <= data_word[7:0];
			prog_block <= block_ok;
			prog_pump_off <= tb_pump_off;
		end
	end

	prog_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.start_i(prog_start),
		.abort_i(dev_rst),
		.busy_o(busy),
		.done_o(done)
	);

	assign busy_o = busy;

	// pump off runs the timer but leaves every cell as it was
	wire write_now = done && !prog_pump_off && !dev_rst;

	// the array changes only at the end of the timed interval, so an
	// aborted cycle leaves every cell as it was
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (write_now) begin
				if ((prog_block ? block_hit(prog_addr, 10'(i)) :
						(prog_addr[8:0] == 9'(i))) &&
						(prot_open || !is_protected(10'(i)))) begin
					mem[i] <= cell_update(mem[i], prog_data);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// is_read is unused; it is tied off here with is_load for a complete command map
	// ------------------------------------------------------------
	wire unused_ok = is_read | is_load;
endmodule
`default_nettype wire

/* File: verif/eeprom_slave_chk.sv */
// checker: pin timing relations of the eeprom slave
// assumes it is bound onto eeprom_slave
`default_nettype none
module eeprom_slave_chk #(
	parameter int PROG_CYCLES = eeprom_ctrl_pkg::PROG_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic bus_clock_line_i,
	input wire logic frame_select_i,
	input wire logic data_i,
	input wire logic data_o,
	input wire logic data_oe_o,
	input wire logic reset_n_i,
	input wire logic option_i,
	input wire logic protect_i,
	input wire logic busy_o
);
	// ----------------------------------------
	// busy length counter
	// ----------------------------------------
	int cnt;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || !busy_o)
			cnt <= 0;
		else
			cnt <= cnt + 1;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	od_low_a: assert property (data_oe_o |-> !data_i)
		else $error("data line not pulled low");
	rst_idle_a: assert property ($fell(srst_i) |-> !busy_o && !data_oe_o)
		else $error("busy or drive after reset");
	busy_max_a: assert property (cnt <= PROG_CYCLES + 1)
		else $error("busy too long");
	busy_len_a: assert property ($fell(busy_o) && reset_n_i &&
		$past(reset_n_i, 2) && $past(reset_n_i, 4) |->
		cnt >= PROG_CYCLES - 1)
		else $error("busy too short");
	abort_a: assert property ($fell(reset_n_i) |-> ##[1:4] !busy_o)
		else $error("reset did not abort");
	abort_oe_a: assert property (!reset_n_i [*4] |-> !data_oe_o)
		else $error("drive kept in reset");
	addr_oe_a: assert property (!frame_select_i [*4] |-> !data_oe_o)
		else $error("drive in address phase");
	commit_a: assert property ($rose(busy_o) |-> !$past(frame_select_i, 2)
		|| !$past(frame_select_i, 4) || !$past(frame_select_i, 6))
		else $error("busy without end pulse");
endmodule
`default_nettype wire

/* File: verif/bus_master_model.sv */
// bus master model: select, bus clock and open-drain data
// assumes the bench resolves the data wire with a pull-up
`default_nettype none
module bus_master_model (
	input wire logic data_i,
	output var logic bus_clock_line_o,
	output var logic frame_select_o,
	output var logic pull_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus_clock_line_o = 1'b1;
		frame_select_o = 1'b1;
		pull_low_o = 1'b0;
	end
	// clock stands high between frames and during a pause
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wr,
		input bit rd, input int pause, output logic [15:0] q);
		int i;
		frame_select_o = 1'b0;
		for (i = 0; i < 8; i++) begin
			bus_clock_line_o = 1'b0;
			pull_low_o = !cmd[i];
			#32 bus_clock_line_o = 1'b1;
			#32;
		end
		pull_low_o = 1'b0;
		frame_select_o = 1'b1;
		#500;
		for (i = 0; i < 16; i++) begin
			bus_clock_line_o = 1'b0;
			pull_low_o = !rd && !wr[i];
			#32 q[i] = data_i;
			bus_clock_line_o = 1'b1;
			#32;
			if (i == 7)
				#(pause);
		end
		pull_low_o = 1'b0;
		#100 frame_select_o = 1'b0;
		#400 frame_select_o = 1'b1;
		#400;
	endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// testbench: eeprom slave driven through the bus master model
// assumes a short programming time for simulation
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG_CYCLES = 200;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rst_n = 1'b1;
	logic opt = 1'b0;
	logic prot = 1'b1;
	logic bcl, sel, pull, dout, doe, busy;
	logic [7:0] cl = 8'h80;
	logic [7:0] cr = 8'h81;
	logic [7:0] cp = 8'h83;
	logic [15:0] w;
	int errors = 0;
	int checked = 0;
	wire logic dline;
	// pull-up: released wire reads high
	assign dline = !(pull || (doe && !dout));
	always #50 clk = !clk;
	bus_master_model m (.data_i(dline), .bus_clock_line_o(bcl),
		.frame_select_o(sel), .pull_low_o(pull));
	eeprom_slave #(.PROG_CYCLES(PROG_CYCLES)) dut (.ref_clk_i(clk),
		.srst_i(srst), .bus_clock_line_i(bcl), .frame_select_i(sel),
		.data_i(dline), .data_o(dout), .data_oe_o(doe),
		.reset_n_i(rst_n), .option_i(opt), .protect_i(prot),
		.busy_o(busy));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("FAIL %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic idle();
		int n;
		for (n = 0; n < PROG_CYCLES + 50 && busy === 1'b1; n++)
			@(negedge clk);
		chk({15'h0, busy}, 16'h0);
	endtask
	// upper word bits set: only ten bits may reach the address
	task automatic ld(input logic [9:0] a);
		m.xfer(cl, {6'h3f, a}, 1'b0, 0, w);
	endtask
	task automatic pr(input logic [7:0] d);
		m.xfer(cp, {8'haa, d}, 1'b0, 0, w);
	endtask
	task automatic rd();
		m.xfer(cr, 16'h0, 1'b1, 0, w);
	endtask
	task automatic pg(input logic [9:0] a, input logic [7:0] d);
		ld(a);
		pr(d);
		idle();
	endtask
	task automatic at(input logic [9:0] a, input logic [15:0] e);
		ld(a);
		rd();
		chk(w, e);
	endtask
	task automatic set_opt(input logic o);
		@(negedge clk);
		opt = o;
		repeat (4) @(negedge clk);
		cl = 8'h80 + {5'h0, o, 2'h0};
		cr = cl + 8'h01;
		cp = cl + 8'h03;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_block();
		pg(10'h204, 8'ha0);
		pg(10'h000, 8'hff);
		pg(10'h002, 8'h55);
		at(10'h014, 16'hff55);
		at(10'h015, 16'hffff);
		pg(10'h003, 8'hf0);
		at(10'h015, 16'hfff0);
		at(10'h014, 16'hff55);
		at(10'h204, 16'hffff);
		pg(10'h204, 8'h28);
		pg(10'h014, 8'h00);
		at(10'h014, 16'hff55);
		pg(10'h204, 8'h80);
		pg(10'h002, 8'h0f);
		at(10'h002, 16'hff05);
		at(10'h014, 16'hff55);
	endtask
	task automatic s_prog();
		pg(10'h014, 8'hff);
		pg(10'h014, 8'h3c);
		at(10'h014, 16'hff3c);
	endtask
	task automatic s_busy();
		ld(10'h014);
		pr(8'h3c);
		ld(10'h015);
		pr(8'h00);
		idle();
		rd();
		chk(w, 16'hff3c);
		pr(8'h3c);
		ld(10'h20e);
		rd();
		chk({15'h0, w[1]}, 16'h1);
		idle();
		ld(10'h20e);
		rd();
		chk({15'h0, w[1]}, 16'h0);
	endtask
	task automatic s_prot();
		logic [9:0] pa [4] = '{10'h005, 10'h010, 10'h1cf, 10'h1d0};
		logic [15:0] pe [4] = '{16'hfff0, 16'hff00, 16'hfff0, 16'hff00};
		int i;
		@(negedge clk);
		prot = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < 4; i++) begin
			pg(pa[i], 8'h00);
			at(pa[i], pe[i]);
		end
		@(negedge clk);
		prot = 1'b1;
	endtask
	task automatic s_opt();
		set_opt(1'b1);
		at(10'h014, 16'hff3c);
		m.xfer(8'h81, 16'h0, 1'b1, 0, w);
		chk(w, 16'hffff);
		set_opt(1'b0);
	endtask
	task automatic s_rst();
		pg(10'h204, 8'ha0);
		ld(10'h014);
		pr(8'h00);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk({15'h0, busy}, 16'h0);
		m.xfer(cr, 16'h0, 1'b1, 50000, w);
		chk(w, 16'hff3c);
		pg(10'h002, 8'h00);
		at(10'h014, 16'hff3c);
	endtask
	initial begin
		#3000000;
		errors++;
		complete_run();
	end
	initial begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		chk({14'h0, busy, doe}, 16'h0);
		chk({15'h0, dline}, 16'h1);
		s_block();
		s_prog();
		s_busy();
		s_prot();
		s_opt();
		s_rst();
		complete_run();
	end
endmodule
bind eeprom_slave eeprom_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.ref_clk_i(ref_clk_i), .srst_i(srst_i),
	.bus_clock_line_i(bus_clock_line_i), .frame_select_i(frame_select_i),
	.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
	.reset_n_i(reset_n_i), .option_i(option_i), .protect_i(protect_i),
	.busy_o(busy_o));
`default_nettype wire
